// ==== rtl/nplc_consts.svh ====
// Constants of the nested priority interrupt controller: offsets,
// field positions, reset values and vector addresses.
// Assumes it is included by the package and the design modules.
`ifndef NPLC_CONSTS_SVH
`define NPLC_CONSTS_SVH
`define NPLC_NUM_VEC     14
`define NPLC_IDX_PRIO_A  8'h24
`define NPLC_IDX_PRIO_B  8'h25
`define NPLC_IDX_PRIO_C  8'h26
`define NPLC_IDX_PRIO_D  8'h27
`define NPLC_IDX_EXT_IRQ_CONTROL_REG    8'h28
`define NPLC_PRIO_RST    8'hff
`define NPLC_PRIO_D_FIX  8'hf0
`define NPLC_EXT_IRQ_CONTROL_REG_RST    8'h00
`define NPLC_CODE_L0     2'b10
`define NPLC_CODE_L3     2'b11
`define NPLC_EXT_IRQ_CONTROL_REG_IPA    0
`define NPLC_EXT_IRQ_CONTROL_REG_IS3    1
`define NPLC_EXT_IRQ_CONTROL_REG_IS2    3
`define NPLC_EXT_IRQ_CONTROL_REG_IPB    5
`define NPLC_EXT_IRQ_CONTROL_REG_IS1    6
`define NPLC_VEC_RESET   16'hfffe
`define NPLC_VEC_TRAP    16'hfffc
`define NPLC_VEC_BASE    16'hfffa
`define NPLC_WAKE_HALT   14'h111c
`define NPLC_WAKE_AHALT  14'h111e
`define NPLC_SENS_FLOW   2'b00
`define NPLC_SENS_RISE   2'b01
`define NPLC_SENS_FALL   2'b10
`define NPLC_SENS_BOTH   2'b11
`endif

// ==== rtl/nplc_pkg.sv ====
// Types shared by the interrupt controller modules.
// Assumes the constants header sits beside it.
`include "nplc_consts.svh"
package nplc_pkg;
  // APB request from the master, published signal names.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } nplc_apb_req_t;
  // One-cycle instruction strobes from the CPU decoder.
  typedef struct packed {
    logic halt;
    logic wait_irq_instr;
    logic enable_irq_instr;
    logic sim;
    logic trap;
    logic pop_condition_code;
    logic irq_return_instr;
  } nplc_cpu_op_t;
  // Maps a two-bit priority code onto a rank 0..3.
  function automatic logic [2:0] nplc_rank(input logic [1:0] c);
    nplc_rank = {1'b0, ~(c[1] ^ c[0]), c[0]};
  endfunction : nplc_rank
endpackage : nplc_pkg

// ==== rtl/nplc_ext_sense.sv ====
// Edge and level detector for one group of external interrupt pins.
// Assumes asynchronous pins and a reset already synchronised.
`timescale 1ns/1ps
`include "nplc_consts.svh"
module nplc_ext_sense #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pins,
  input  wire logic [1:0]   sens,
  input  wire logic         inv,
  output logic              evt,
  output logic              low
);
  import nplc_pkg::*;
  logic [W-1:0] meta_ff, sync_ff, prev_ff;
  logic [W-1:0] cur_p, old_p;
  logic         fall, rise;

  // Inversion turns the low-level mode into rising edge plus high level.
  always_comb begin
    cur_p = sync_ff ^ {W{inv}};
    old_p = prev_ff ^ {W{inv}};
    fall  = |(old_p & ~cur_p);
    rise  = |(~old_p & cur_p);
    low   = (sens == `NPLC_SENS_FLOW) && (|(~cur_p));
    case (sens)
      `NPLC_SENS_FLOW: evt = fall;
      `NPLC_SENS_RISE: evt = rise;
      `NPLC_SENS_FALL: evt = fall;
      default:         evt = fall | rise;
    endcase
  end

  // Two stages before anything looks at the pins; pins idle high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '1;
      sync_ff <= '1;
      prev_ff <= '1;
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
endmodule : nplc_ext_sense

// ==== rtl/nplc_prio_arb.sv ====
// Combinational arbiter over the fourteen vectors.
// Assumes requests are already enabled, masked and halt-filtered.
`timescale 1ns/1ps
module nplc_prio_arb #(
  parameter int N = 14
) (
  input  wire logic [N-1:0]   req,
  input  wire logic [2*N-1:0] fields,
  input  wire logic [1:0]     cur,
  output logic                hit,
  output logic [3:0]          idx
);
  import nplc_pkg::*;
  logic [2:0] best;
  logic [2:0] lv;

  // Walk from lowest fixed order so that ties fall to the lower index.
  always_comb begin
    best = 3'h0;
    hit  = 1'b0;
    idx  = 4'h0;
    lv   = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      // Vector 0 ranks above every level; its field is ignored.
      lv = (i == 0) ? 3'h4 : nplc_rank(fields[2*i +: 2]);
      if (req[i] && (lv > nplc_rank(cur)) && (!hit || lv >= best)) begin
        hit  = 1'b1;
        best = lv;
        idx  = 4'(i);
      end
    end
  end
endmodule : nplc_prio_arb

// ==== rtl/nplc_ctrl.sv ====
// Top of the nested priority interrupt controller: APB registers,
// current priority, external pending latches and request to the CPU.
// Assumes an APB master on CLK, CPU strobes on CLK, pins asynchronous.
`timescale 1ns/1ps
`include "nplc_consts.svh"
module nplc_ctrl #(
  parameter int NV = `NPLC_NUM_VEC
) (
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire nplc_pkg::nplc_apb_req_t APB_REQ,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic [NV-1:0]         PERIPH_REQ,
  input  wire nplc_pkg::nplc_cpu_op_t CPU_OP,
  input  wire logic [1:0]            STACK_PRIO,
  input  wire logic                  IRQ_ACK,
  input  wire logic                  HALT_MODE,
  input  wire logic                  ACTIVE_HALT,
  input  wire logic [5:0]            EXT0_PINS,
  input  wire logic [3:0]            EXT1_PINS,
  input  wire logic [5:0]            EXT2_PINS,
  input  wire logic [2:0]            EXT_GND_FORCED,
  output logic                       IRQ_REQ,
  output logic [15:0]                IRQ_VECTOR,
  output logic [1:0]                 CUR_PRIO,
  output logic                       BR_MASKED,
  output logic                       BR_UNMASKED,
  output logic                       WAKE
);
  import nplc_pkg::*;

  // Reset release synchroniser.
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Register state.
  logic [3:0][7:0] prio_ff;
  logic [3:0][7:0] nxt_prio;
  logic [7:0]      ext_irq_control_reg_ff;
  logic [7:0]      nxt_ext_irq_control_reg;
  logic [1:0]      cur_ff;
  logic [1:0]      nxt_cur;
  logic [2:0]      ext_pend_ff;
  logic [2:0]      nxt_ext_pend;
  logic [2:0]      gnd_meta_ff;
  logic [2:0]      gnd_sync_ff;

  // APB answer state.
  logic        pready_ff;
  logic        nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;
  logic        nxt_pslverr;

  // Request outputs.
  logic        irq_req_ff;
  logic        nxt_irq_req;
  logic [3:0]  idx_ff;
  logic [3:0]  nxt_idx;
  logic [15:0] vec_ff;
  logic [15:0] nxt_vec;
  logic        wake_ff;
  logic        nxt_wake;
  logic        br_m_ff;
  logic        nxt_br_m;
  logic        br_um_ff;
  logic        nxt_br_um;

  // Decode helpers.
  logic       acc;
  logic       wr;
  logic [5:0] word;
  logic       hit_prio;
  logic       hit_ext_irq_control_reg;
  logic [1:0] sel;

  // External detector outputs, one per pin group.
  logic [4:0] grp_evt;
  logic [4:0] grp_low;
  logic [2:0] ext_evt;
  logic [2:0] ext_low;
  logic [2:0] ext_req;

  // Arbitration inputs and result.
  logic [NV-1:0] all_req;
  logic [NV-1:0] wake_ok;
  logic [NV-1:0] arb_req;
  logic [31:0]   prio_flat;
  logic          arb_hit;
  logic [3:0]    arb_idx;

  // Printed offsets are word indices; the byte address is four times that.
  always_comb begin
    acc      = APB_REQ.psel && APB_REQ.penable;
    wr       = acc && pready_ff && APB_REQ.pwrite;
    word     = APB_REQ.paddr[7:2];
    hit_prio = (APB_REQ.paddr[1:0] == 2'h0)
            && (word >= 6'(`NPLC_IDX_PRIO_A))
            && (word <= 6'(`NPLC_IDX_PRIO_D));
    hit_ext_irq_control_reg = (APB_REQ.paddr[1:0] == 2'h0)
            && (word == 6'(`NPLC_IDX_EXT_IRQ_CONTROL_REG));
    sel      = word[1:0];
  end

  // One wait state: read data and error are registered on the same edge that raises pready.
  always_comb begin
    nxt_pready  = acc && !pready_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (acc && !pready_ff) begin
      nxt_pslverr = !(hit_prio || hit_ext_irq_control_reg);
      if (hit_prio) begin
        nxt_prdata = {24'h0, prio_ff[sel]};
      end else if (hit_ext_irq_control_reg) begin
        nxt_prdata = {24'h0, ext_irq_control_reg_ff};
      end else begin
        nxt_prdata = 32'h0;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Priority field writes; a level-0 code keeps the stored pair.
  always_comb begin
    nxt_prio = prio_ff;
    if (wr && hit_prio) begin
      for (int f = 0; f < 4; f++) begin
        if (APB_REQ.pwdata[2*f +: 2] != `NPLC_CODE_L0) begin
          nxt_prio[sel][2*f +: 2] = APB_REQ.pwdata[2*f +: 2];
        end
      end
    end
    // Vectors fourteen and up do not exist; their bits read as one.
    nxt_prio[3] = nxt_prio[3] | `NPLC_PRIO_D_FIX;
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      prio_ff <= {4{`NPLC_PRIO_RST}};
    end else begin
      prio_ff <= nxt_prio;
    end
  end

  // Sensitivity writes only land at level 3, so a half-changed setting
  // cannot trigger while interrupts are open.
  always_comb begin
    nxt_ext_irq_control_reg = ext_irq_control_reg_ff;
    if (wr && hit_ext_irq_control_reg && (cur_ff == `NPLC_CODE_L3)) begin
      nxt_ext_irq_control_reg = APB_REQ.pwdata[7:0];
    end
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ext_irq_control_reg_ff <= `NPLC_EXT_IRQ_CONTROL_REG_RST;
    end else begin
      ext_irq_control_reg_ff <= nxt_ext_irq_control_reg;
    end
  end

  // Pin groups: invertible halves of vectors 2 and 4 get the polarity
  // bits, which gives rising edge plus high level only there.
  nplc_ext_sense #(.W(3)) u_e0_hi (
    .clk   (CLK),
    .rst_n (rst_n_ff),
    .pins  (EXT0_PINS[5:3]),
    .sens  (ext_irq_control_reg_ff[`NPLC_EXT_IRQ_CONTROL_REG_IS3 +: 2]),
    .inv   (ext_irq_control_reg_ff[`NPLC_EXT_IRQ_CONTROL_REG_IPA]),
    .evt   (grp_evt[0]),
    .low   (grp_low[0])
  );
  nplc_ext_sense #(.W(3)) u_e0_lo (
    .clk   (CLK),
    .rst_n (rst_n_ff),
    .pins  (EXT0_PINS[2:0]),
    .sens  (ext_irq_control_reg_ff[`NPLC_EXT_IRQ_CONTROL_REG_IS3 +: 2]),
    .inv   (1'b0),
    .evt   (grp_evt[1]),
    .low   (grp_low[1])
  );
  nplc_ext_sense #(.W(4)) u_e1 (
    .clk   (CLK),
    .rst_n (rst_n_ff),
    .pins  (EXT1_PINS),
    .sens  (ext_irq_control_reg_ff[`NPLC_EXT_IRQ_CONTROL_REG_IS2 +: 2]),
    .inv   (1'b0),
    .evt   (grp_evt[2]),
    .low   (grp_low[2])
  );
  nplc_ext_sense #(.W(3)) u_e2_hi (
    .clk   (CLK),
    .rst_n (rst_n_ff),
    .pins  (EXT2_PINS[5:3]),
    .sens  (ext_irq_control_reg_ff[`NPLC_EXT_IRQ_CONTROL_REG_IS1 +: 2]),
    .inv   (ext_irq_control_reg_ff[`NPLC_EXT_IRQ_CONTROL_REG_IPB]),
    .evt   (grp_evt[3]),
    .low   (grp_low[3])
  );
  nplc_ext_sense #(.W(3)) u_e2_lo (
    .clk   (CLK),
    .rst_n (rst_n_ff),
    .pins  (EXT2_PINS[2:0]),
    .sens  (ext_irq_control_reg_ff[`NPLC_EXT_IRQ_CONTROL_REG_IS1 +: 2]),
    .inv   (1'b0),
    .evt   (grp_evt[4]),
    .low   (grp_low[4])
  );

  // Pins of one vector are ORed; a grounded pin masks the vector.
  always_comb begin
    ext_evt = {grp_evt[4] | grp_evt[3], grp_evt[2], grp_evt[1] | grp_evt[0]};
    ext_low = {grp_low[4] | grp_low[3], grp_low[2], grp_low[1] | grp_low[0]};
    ext_req = (ext_pend_ff | ext_low) & ~gnd_sync_ff;
  end

  // Edge latches: a new edge beats the clear in the same cycle.
  always_comb begin
    nxt_ext_pend = ext_pend_ff;
    if (wr && hit_ext_irq_control_reg && (cur_ff == `NPLC_CODE_L3)
        && (APB_REQ.pwdata[7:0] != ext_irq_control_reg_ff)) begin
      nxt_ext_pend = 3'h0;
    end
    if (IRQ_ACK && irq_req_ff && (idx_ff >= 4'h2) && (idx_ff <= 4'h4)) begin
      nxt_ext_pend[2'(idx_ff - 4'h2)] = 1'b0;
    end
    nxt_ext_pend = nxt_ext_pend | ext_evt;
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ext_pend_ff <= 3'h0;
      gnd_meta_ff <= 3'h0;
      gnd_sync_ff <= 3'h0;
    end else begin
      ext_pend_ff <= nxt_ext_pend;
      gnd_meta_ff <= EXT_GND_FORCED;
      gnd_sync_ff <= gnd_meta_ff;
    end
  end

  // Request set; in halt only wake-capable vectors take part.
  always_comb begin
    all_req = PERIPH_REQ;
    all_req[4:2] = ext_req;
    wake_ok = ACTIVE_HALT ? `NPLC_WAKE_AHALT : `NPLC_WAKE_HALT;
    arb_req = HALT_MODE ? (all_req & wake_ok) : all_req;
    // Flat view of the priority bytes so the arbiter sees one field per vector.
    prio_flat = prio_ff;
  end

  nplc_prio_arb #(.N(NV)) u_arb (
    .req    (arb_req),
    .fields (prio_flat[2*NV-1:0]),
    .cur    (cur_ff),
    .hit    (arb_hit),
    .idx    (arb_idx)
  );

  // Current priority: entry takes the vector field, level 3 for vector 0, instructions load
  // fixed codes, return and pop take the stacked value.
  always_comb begin
    nxt_cur = cur_ff;
    if (IRQ_ACK && irq_req_ff) begin
      if (idx_ff == 4'h0) begin
        nxt_cur = `NPLC_CODE_L3;
      end else begin
        nxt_cur = nxt_prio[idx_ff[3:2]][2*idx_ff[1:0] +: 2];
      end
    end else if (CPU_OP.irq_return_instr || CPU_OP.pop_condition_code) begin
      nxt_cur = STACK_PRIO;
    end else if (CPU_OP.sim || CPU_OP.trap) begin
      nxt_cur = `NPLC_CODE_L3;
    end else if (CPU_OP.enable_irq_instr || CPU_OP.wait_irq_instr || CPU_OP.halt) begin
      nxt_cur = `NPLC_CODE_L0;
    end
    nxt_br_m = (nxt_cur == `NPLC_CODE_L3);
    nxt_br_um = (nxt_cur != `NPLC_CODE_L3);
  end

  // Vector to the CPU; a request is withdrawn in the cycle after the acknowledge
  // so that a stale entry is never presented twice.
  always_comb begin
    nxt_irq_req = arb_hit && !IRQ_ACK;
    nxt_idx     = arb_hit ? arb_idx : idx_ff;
    nxt_vec     = `NPLC_VEC_BASE - {11'h0, nxt_idx, 1'b0};
    nxt_wake    = HALT_MODE && arb_hit;
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cur_ff     <= `NPLC_CODE_L3;
      br_m_ff    <= 1'b1;
      br_um_ff   <= 1'b0;
      irq_req_ff <= 1'b0;
      idx_ff     <= 4'h0;
      vec_ff     <= `NPLC_VEC_RESET;
      wake_ff    <= 1'b0;
    end else begin
      cur_ff     <= nxt_cur;
      br_m_ff    <= nxt_br_m;
      br_um_ff   <= nxt_br_um;
      irq_req_ff <= nxt_irq_req;
      idx_ff     <= nxt_idx;
      vec_ff     <= nxt_vec;
      wake_ff    <= nxt_wake;
    end
  end

  // Outputs straight from flip-flops.
  assign PRDATA      = prdata_ff;
  assign PREADY      = pready_ff;
  assign PSLVERR     = pslverr_ff;
  assign IRQ_REQ     = irq_req_ff;
  assign IRQ_VECTOR  = vec_ff;
  assign CUR_PRIO    = cur_ff;
  assign BR_MASKED   = br_m_ff;
  assign BR_UNMASKED = br_um_ff;
  assign WAKE        = wake_ff;
endmodule : nplc_ctrl

// ==== tb/nplc_ctrl_monitor.sv ====
// Concurrent checks on the ports of the interrupt controller top.
// Assumes one clock and the asynchronous active-low reset of the top.
`timescale 1ns/1ps
module nplc_ctrl_monitor
  import nplc_pkg::*;
#(
  parameter int NV = 14
) (
  input wire logic                    CLK,
  input wire logic                    ARST_N,
  input wire nplc_pkg::nplc_apb_req_t APB_REQ,
  input wire logic                    PREADY,
  input wire logic [NV-1:0]           PERIPH_REQ,
  input wire nplc_pkg::nplc_cpu_op_t  CPU_OP,
  input wire logic [1:0]              STACK_PRIO,
  input wire logic                    IRQ_ACK,
  input wire logic                    IRQ_REQ,
  input wire logic [15:0]             IRQ_VECTOR,
  input wire logic [1:0]              CUR_PRIO,
  input wire logic                    BR_MASKED,
  input wire logic                    BR_UNMASKED,
  input wire logic                    WAKE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // An acknowledge outranks any strobe, so the strobe checks exclude it.
  a_branch_flags: assert property (
    (BR_MASKED == (CUR_PRIO == 2'b11)) && (BR_UNMASKED != BR_MASKED))
    else $error("branch flags disagree with current priority");
  a_enable_level0: assert property (
    (CPU_OP.enable_irq_instr || CPU_OP.wait_irq_instr || CPU_OP.halt) && !IRQ_ACK |=> CUR_PRIO == 2'b10)
    else $error("enable, wait or halt did not load level 0");
  a_disable_level3: assert property (
    (CPU_OP.sim || CPU_OP.trap) && !IRQ_ACK |=> CUR_PRIO == 2'b11)
    else $error("disable or trap did not load level 3");
  a_return_restores: assert property (
    (CPU_OP.irq_return_instr || CPU_OP.pop_condition_code) && !IRQ_ACK |=> CUR_PRIO == $past(STACK_PRIO))
    else $error("return did not restore the stacked priority");
  a_prio_holds: assert property (!IRQ_ACK && CPU_OP == '0 |=> $stable(CUR_PRIO))
    else $error("current priority moved without a cause");
  a_ack_drops_req: assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ)
    else $error("request stayed up after acknowledge");
  a_estop_level3: assert property (
    IRQ_ACK && IRQ_REQ && IRQ_VECTOR == 16'hfffa |=> CUR_PRIO == 2'b11)
    else $error("emergency stop service did not set level 3");
  a_vector_map: assert property (
    IRQ_REQ |-> !IRQ_VECTOR[0] && IRQ_VECTOR <= 16'hfffa && IRQ_VECTOR >= 16'hffe0)
    else $error("vector address outside the table");
  a_masked_estop: assert property (
    CUR_PRIO == 2'b11 && $past(CUR_PRIO) == 2'b11 && IRQ_REQ |-> IRQ_VECTOR == 16'hfffa)
    else $error("request presented at level 3");
  a_pready_wait: assert property ($rose(APB_REQ.penable) && APB_REQ.psel |-> !PREADY ##1 PREADY)
    else $error("ready not after exactly one wait state");
  c_ack: cover property (IRQ_ACK && IRQ_REQ);
  c_timer_req: cover property (PERIPH_REQ[9] && IRQ_REQ);
  c_wake: cover property (WAKE);
endmodule : nplc_ctrl_monitor

bind nplc_ctrl nplc_ctrl_monitor #(.NV(NV)) u_nplc_ctrl_monitor (
  .CLK(CLK), .ARST_N(ARST_N), .APB_REQ(APB_REQ), .PREADY(PREADY), .PERIPH_REQ(PERIPH_REQ),
  .CPU_OP(CPU_OP), .STACK_PRIO(STACK_PRIO), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ),
  .IRQ_VECTOR(IRQ_VECTOR), .CUR_PRIO(CUR_PRIO), .BR_MASKED(BR_MASKED),
  .BR_UNMASKED(BR_UNMASKED), .WAKE(WAKE));

// ==== tb/nplc_cpu_model.sv ====
// CPU side partner: acknowledges a presented request after a set wait.
// Assumes the controller clock and reset; acks only while enabled.
`timescale 1ns/1ps
module nplc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_wait,
  input  wire logic       irq_req,
  output logic            irq_ack
);
  logic [3:0] cnt_ff;
  // The ack is one cycle and never back to back, so it meets a live request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 4'h0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      cnt_ff  <= 4'h0;
      if (irq_req && ack_en && !irq_ack) begin
        if (cnt_ff == ack_wait) irq_ack <= 1'b1;
        else cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule : nplc_cpu_model

// ==== tb/tb_nested_priority_interrupt_ctrl.sv ====
// Self-checking bench of the interrupt controller top.
// Assumes the package, the top module, the monitor and the CPU model.
`timescale 1ns/1ps
module tb_nested_priority_interrupt_ctrl;
  import nplc_pkg::*;
  localparam nplc_cpu_op_t OP_HALT = 7'h40;
  localparam nplc_cpu_op_t OP_WFI  = 7'h20;
  localparam nplc_cpu_op_t OP_RIM  = 7'h10;
  localparam nplc_cpu_op_t OP_SIM  = 7'h08;
  localparam nplc_cpu_op_t OP_IRQ_RETURN_INSTR = 7'h01;
  logic          CLK = 1'b0;
  logic          ARST_N = 1'b0;
  nplc_apb_req_t apb_req = '0;
  nplc_cpu_op_t  cpu_op = '0;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, err, irq_ack, irq_req, br_masked, br_unmasked, wake;
  logic [13:0]   periph_req = '0;
  logic [1:0]    stack_prio = 2'b10;
  logic [1:0]    cur_prio;
  logic          halt_mode = 1'b0;
  logic          active_halt = 1'b0;
  logic          ack_en = 1'b0;
  logic [3:0]    ack_wait = 4'h2;
  logic [5:0]    ext0_pins = 6'h3f;
  logic [2:0]    ext_gnd_forced = 3'h0;
  logic [15:0]   irq_vector;
  int            fail_count = 0;
  int            checks = 0;

  always #4 CLK = ~CLK;

  nplc_ctrl u_nplc_ctrl (.CLK(CLK), .ARST_N(ARST_N), .APB_REQ(apb_req), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PERIPH_REQ(periph_req), .CPU_OP(cpu_op),
    .STACK_PRIO(stack_prio), .IRQ_ACK(irq_ack), .HALT_MODE(halt_mode),
    .ACTIVE_HALT(active_halt), .EXT0_PINS(ext0_pins), .EXT1_PINS(4'hf), .EXT2_PINS(6'h3f),
    .EXT_GND_FORCED(ext_gnd_forced), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector),
    .CUR_PRIO(cur_prio), .BR_MASKED(br_masked), .BR_UNMASKED(br_unmasked), .WAKE(wake));

  nplc_cpu_model u_nplc_cpu_model (.clk(CLK), .rst_n(ARST_N), .ack_en(ack_en),
    .ack_wait(ack_wait), .irq_req(irq_req), .irq_ack(irq_ack));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until ready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge CLK);
    apb_req.penable <= 1'b1;
    do @(posedge CLK); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic op(input nplc_cpu_op_t o);
    @(posedge CLK);
    cpu_op <= o;
    @(posedge CLK);
    cpu_op <= '0;
  endtask : op

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc

  task automatic print_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // A hang ends the run as a failure.
  initial begin
    cyc(4000);
    fail_count++;
    print_verdict();
  end

  initial begin
    cyc(16);
    ARST_N <= 1'b1;
    cyc(3);
    // Reset values, control register and an unmapped word.
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'h90 + 8'(4 * i), 32'h0);
      chk(rd, 32'hff);
    end
    apb(1'b0, 8'ha0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'ha4, 32'h0);
    chk(32'(err), 32'h1);
    // A field written with the level-0 code keeps its old value.
    apb(1'b1, 8'h90, 32'hcf);
    apb(1'b1, 8'h90, 32'h64);
    apb(1'b0, 8'h90, 32'h0);
    chk(rd, 32'h44);
    apb(1'b1, 8'h9c, 32'h0);
    apb(1'b0, 8'h9c, 32'h0);
    chk(rd, 32'hf0);
    // Tie broken by fixed order, then the higher level wins.
    op(OP_RIM);
    periph_req <= 14'h0300;
    cyc(3);
    chk(32'(irq_vector), 32'hffea);
    apb(1'b1, 8'h98, 32'hf1);
    cyc(3);
    chk(32'(irq_vector), 32'hffe8);
    ack_en <= 1'b1;
    cyc(8);
    ack_en <= 1'b0;
    chk(32'(cur_prio), 32'h0);
    chk(32'(irq_req), 32'h0);
    op(OP_IRQ_RETURN_INSTR);
    cyc(2);
    chk(32'(cur_prio), 32'h2);
    chk(32'(irq_req), 32'h1);
    // Halt: only wake-capable vectors, time base only from active-halt.
    op(OP_SIM);
    op(OP_HALT);
    halt_mode <= 1'b1;
    cyc(3);
    chk(32'(cur_prio), 32'h2);
    chk(32'(wake), 32'h1);
    periph_req <= 14'h0200;
    cyc(3);
    chk(32'(wake), 32'h0);
    periph_req <= 14'h0002;
    cyc(3);
    chk(32'(wake), 32'h0);
    active_halt <= 1'b1;
    cyc(3);
    chk(32'(wake), 32'h1);
    halt_mode <= 1'b0;
    active_halt <= 1'b0;
    periph_req <= 14'h0001;
    // Emergency stop is presented even at level 3.
    op(OP_SIM);
    cyc(3);
    chk(32'(br_masked), 32'h1);
    chk(32'(irq_vector), 32'hfffa);
    op(OP_RIM);
    cyc(2);
    chk(32'(br_unmasked), 32'h1);
    ack_en <= 1'b1;
    cyc(6);
    ack_en <= 1'b0;
    periph_req <= 14'h0;
    chk(32'(cur_prio), 32'h3);
    op(OP_WFI);
    cyc(2);
    chk(32'(cur_prio), 32'h2);
    // External vector 2 on a falling edge; control writes only at level 3.
    op(OP_SIM);
    apb(1'b1, 8'ha0, 32'h04);
    op(OP_RIM);
    apb(1'b1, 8'ha0, 32'hff);
    apb(1'b0, 8'ha0, 32'h0);
    chk(rd, 32'h04);
    ext0_pins <= 6'h3e;
    cyc(8);
    chk(32'(irq_vector), 32'hfff6);
    chk(32'(irq_req), 32'h1);
    ext_gnd_forced <= 3'h1;
    cyc(8);
    chk(32'(irq_req), 32'h0);
    ext_gnd_forced <= 3'h0;
    cyc(8);
    chk(32'(irq_req), 32'h1);
    op(OP_SIM);
    apb(1'b1, 8'ha0, 32'h06);
    op(OP_RIM);
    cyc(3);
    chk(32'(irq_req), 32'h0);
    // Both edges latch; the polarity bit turns low level into high level.
    ext0_pins <= 6'h07;
    cyc(8);
    chk(32'(irq_req), 32'h1);
    op(OP_SIM);
    apb(1'b1, 8'ha0, 32'h01);
    op(OP_RIM);
    cyc(3);
    chk(32'(irq_req), 32'h0);
    ext0_pins <= 6'h0f;
    cyc(8);
    chk(32'(irq_vector), 32'hfff6);
    chk(32'(irq_req), 32'h1);
    print_verdict();
  end
endmodule : tb_nested_priority_interrupt_ctrl
